// ==== hsr_pkg.sv ====
// constants and types shared by the hold, conversion and readout logic
package hsr_pkg;
   localparam int          CLK_MHZ        = 200;
   localparam int          SYS_CLK_MHZ    = 40;
   localparam int          BIT_NS         = 25;
   localparam int          CLK_PER_BIT    = (BIT_NS * CLK_MHZ + 999) / 1000;
   localparam int          NUM_CH         = 64;
   localparam int          CH_W           = 6;
   localparam int          DATA_W         = 12;
   localparam int          BITIDX_W       = 4;
   localparam int          CFG_BIT_LOW    = 25;
   localparam int          CFG_BIT_MID    = 26;
   localparam logic [5:0]  LAST_CH        = 6'h3F;
   localparam logic [11:0] CNT_ZERO       = 12'h000;
   localparam logic [11:0] MAX_12         = 12'hFFF;
   localparam logic [11:0] MAX_10         = 12'h3FF;
   localparam logic [11:0] MAX_8          = 12'h0FF;
   localparam logic [3:0]  LAST_BIT_12    = 4'hB;
   localparam logic [3:0]  LAST_BIT_10    = 4'h9;
   localparam logic [3:0]  LAST_BIT_8     = 4'h7;
   localparam int          SHIFT_10       = 2;
   localparam int          SHIFT_8        = 4;

   typedef enum logic [2:0] {
      RES_12 = 3'b001,
      RES_10 = 3'b010,
      RES_8  = 3'b100
   } hsr_res_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_SEND = 3'b100
   } hsr_state_t;
endpackage : hsr_pkg

// ==== hsr_result_mem.sv ====
// per-channel conversion result store with a registered read port
`timescale 1ns/1ps
module hsr_result_mem (
   input  wire logic                          clk_in,
   input  wire logic                          clk_en_in,
   input  wire logic [hsr_pkg::NUM_CH-1:0]    wr_en_in,
   input  wire logic [hsr_pkg::DATA_W-1:0]    wr_data_in,
   input  wire logic [hsr_pkg::CH_W-1:0]      rd_addr_in,
   output logic      [hsr_pkg::DATA_W-1:0]    rd_data_out
);
   logic [hsr_pkg::DATA_W-1:0] mem [hsr_pkg::NUM_CH];

   // every firing channel copies the same shared counter state
   always_ff @(posedge clk_in) begin
      if (clk_en_in) begin
         for (int i = 0; i < hsr_pkg::NUM_CH; i++) begin
            if (wr_en_in[i]) begin
               mem[i] <= wr_data_in;
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (clk_en_in) begin
         rd_data_out <= mem[rd_addr_in];
      end
   end
endmodule : hsr_result_mem

// ==== hsr_adc_readout.sv ====
// hold sampling, shared ramp conversion and serial readout of 64 channels
//
// Summary of operation
// R1: Two hold inputs common to all 64 channels each steer one analog memory per channel.
// R2: A memory follows the shaper while its hold is high and keeps the value once it is low.
// R3: The controller should drop the hold about one peaking time after the input to catch the peak.
// R4: The controller may drop the hold right after or before the input to catch the baseline.
// R5: Conversion is timed by the external 40 MHz system clock from ramp start to comparator crossing.
// R6: The shared ramp starts on the falling edge of the conversion-start input.
// R7: The first system clock tick after the start falling edge starts the Gray counter and each resynchronised comparator latches it.
// R8: One 12-bit Gray counter and one ramp serve all channels, each channel only compares and stores.
// R9: An N-bit conversion lasts 2^N system clock periods and lower resolutions end sooner.
// R10: Serial readout starts by itself at the end of conversion.
// R11: Transmit-active rises with the first data bit, stays high to the last, on its own pin.
// R12: In 12-bit mode 768 bits go out one per 25 ns, so the strobe lasts 19.2 us.
// R13: Channel 0 goes first, LSB first, then channels in ascending order to 63.
// R14: The transmission shortens with resolution to 16 us at 10 bits and 12.8 us at 8 bits.
// R15: The controller should pulse ADC reset low 25 ns with the start falling edge on its rising edge.
// R16: The low-resolution select gives 8 bits, the mid select 10 bits, neither gives 12 bits.
// R17: The controller samples data on the system clock while transmit-active is high.
`timescale 1ns/1ps
module hsr_adc_readout (
   input  wire logic                                     clk_in,
   input  wire logic                                     rst_in,
   input  wire logic                                     clk_en_in,
   input  wire logic                                     sys_clk_in,
   input  wire logic                                     adc_reset_n_in,
   input  wire logic                                     start_conv_in,
   input  wire logic                                     peak_hold_in,
   input  wire logic                                     second_hold_in,
   input  wire logic                                     mem_sel_in,
   input  wire logic                                     slope_sel_low_res_in,
   input  wire logic                                     slope_sel_mid_res_in,
   input  wire logic [hsr_pkg::NUM_CH*hsr_pkg::DATA_W-1:0] shaper_amp_in,
   output logic                                          serial_data_out,
   output logic                                          transmit_active_out,
   output logic                                          converting_out
);
   hsr_pkg::hsr_state_t                state;
   hsr_pkg::hsr_res_t                  res;
   logic                               sys_prev;
   logic                               start_prev;
   logic                               sel_second;
   logic                               cnt_run;
   logic [hsr_pkg::DATA_W-1:0]         cnt;
   logic [hsr_pkg::NUM_CH-1:0]         fired;
   logic [hsr_pkg::NUM_CH-1:0]         next_fire;
   logic [hsr_pkg::NUM_CH-1:0]         wr_en;
   logic [hsr_pkg::DATA_W-1:0]         wr_gray;
   logic [hsr_pkg::DATA_W-1:0]         held_peak   [hsr_pkg::NUM_CH];
   logic [hsr_pkg::DATA_W-1:0]         held_second [hsr_pkg::NUM_CH];
   logic [hsr_pkg::CH_W-1:0]           rd_addr;
   logic [hsr_pkg::DATA_W-1:0]         rd_data;
   logic [hsr_pkg::DATA_W-1:0]         rd_bin;
   logic [hsr_pkg::DATA_W-1:0]         shreg;
   logic [hsr_pkg::BITIDX_W-1:0]       bit_idx;
   logic                               tick;
   logic                               start_fall;
   logic                               cnt_last;
   logic                               bit_last;
   logic [hsr_pkg::DATA_W-1:0]         ramp;

   function automatic logic [11:0] max_count(input hsr_pkg::hsr_res_t r);
      unique case (r)
         hsr_pkg::RES_8:  max_count = hsr_pkg::MAX_8;
         hsr_pkg::RES_10: max_count = hsr_pkg::MAX_10;
         default:         max_count = hsr_pkg::MAX_12;
      endcase
   endfunction : max_count

   function automatic logic [3:0] last_bit(input hsr_pkg::hsr_res_t r);
      unique case (r)
         hsr_pkg::RES_8:  last_bit = hsr_pkg::LAST_BIT_8;
         hsr_pkg::RES_10: last_bit = hsr_pkg::LAST_BIT_10;
         default:         last_bit = hsr_pkg::LAST_BIT_12;
      endcase
   endfunction : last_bit

   // ramp slope: coarser resolution climbs the full scale in fewer ticks
   function automatic logic [11:0] ramp_level(input logic [11:0] c,
                                              input hsr_pkg::hsr_res_t r);
      unique case (r)
         hsr_pkg::RES_8:  ramp_level = c << hsr_pkg::SHIFT_8;
         hsr_pkg::RES_10: ramp_level = c << hsr_pkg::SHIFT_10;
         default:         ramp_level = c;
      endcase
   endfunction : ramp_level

   function automatic logic [11:0] gray_to_bin(input logic [11:0] g);
      logic [11:0] b;
      b = 12'h000;
      b[11] = g[11];
      for (int i = 10; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : gray_to_bin

   // system clock taken as a synchronous level, its rising edge is the count tick
   assign tick       = sys_clk_in & ~sys_prev; // R5
   assign start_fall = start_prev & ~start_conv_in; // R6
   assign cnt_last   = (cnt == max_count(res)); // R9
   assign bit_last   = (bit_idx == last_bit(res));
   assign ramp       = ramp_level(cnt, res);
   assign rd_bin     = gray_to_bin(rd_data);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sys_prev   <= 1'b0;
         start_prev <= 1'b1;
      end else if (clk_en_in) begin
         sys_prev   <= sys_clk_in;
         start_prev <= start_conv_in;
      end
   end

   // track while hold high, freeze on low
   always_ff @(posedge clk_in) begin
      if (clk_en_in) begin
         for (int i = 0; i < hsr_pkg::NUM_CH; i++) begin
            if (peak_hold_in) begin // R1 R2
               held_peak[i] <= shaper_amp_in[i*hsr_pkg::DATA_W +: hsr_pkg::DATA_W];
            end
            if (second_hold_in) begin // R1 R2
               held_second[i] <= shaper_amp_in[i*hsr_pkg::DATA_W +: hsr_pkg::DATA_W];
            end
         end
      end
   end

   // per-channel comparator; unfired channels are forced at full scale
   always_comb begin
      next_fire = '0;
      for (int i = 0; i < hsr_pkg::NUM_CH; i++) begin
         if (state == hsr_pkg::ST_CONV && tick && cnt_run && !fired[i]) begin
            next_fire[i] = cnt_last ||
                           (ramp >= (sel_second ? held_second[i] : held_peak[i])); // R8
         end
      end
   end

   // one register stage resynchronises the comparators and the counter value
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_en   <= '0;
         wr_gray <= hsr_pkg::CNT_ZERO;
      end else if (clk_en_in) begin
         wr_en   <= next_fire; // R7
         wr_gray <= cnt ^ (cnt >> 1); // R7
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || !adc_reset_n_in) begin
         state      <= hsr_pkg::ST_IDLE;
         res        <= hsr_pkg::RES_12;
         sel_second <= 1'b0;
         cnt_run    <= 1'b0;
         cnt        <= hsr_pkg::CNT_ZERO;
         fired      <= '0;
      end else if (clk_en_in) begin
         unique case (state)
            hsr_pkg::ST_IDLE: begin
               if (start_fall) begin // R6
                  state      <= hsr_pkg::ST_CONV;
                  sel_second <= mem_sel_in;
                  cnt_run    <= 1'b0;
                  cnt        <= hsr_pkg::CNT_ZERO;
                  fired      <= '0;
                  // low-resolution select wins if both are set
                  if (slope_sel_low_res_in) begin // R16
                     res <= hsr_pkg::RES_8;
                  end else if (slope_sel_mid_res_in) begin // R16
                     res <= hsr_pkg::RES_10;
                  end else begin
                     res <= hsr_pkg::RES_12;
                  end
               end
            end
            hsr_pkg::ST_CONV: begin
               if (tick) begin
                  if (!cnt_run) begin
                     cnt_run <= 1'b1; // R7
                  end else begin
                     fired <= fired | next_fire;
                     cnt   <= cnt + 12'h001;
                     if (cnt_last) begin // R9 R10
                        state   <= hsr_pkg::ST_SEND;
                        cnt_run <= 1'b0;
                     end
                  end
               end
            end
            hsr_pkg::ST_SEND: begin
               if (tick && !transmit_active_out && rd_addr == 6'h00 && bit_idx == 4'h0
                   && fired == '0) begin
                  state <= hsr_pkg::ST_IDLE;
               end else if (tick && transmit_active_out && rd_addr == 6'h00
                            && bit_idx == 4'h0) begin
                  state <= hsr_pkg::ST_IDLE;
               end
               // kept until the first readout tick, which needs it to start sending
               if (tick) begin
                  fired <= '0;
               end
            end
            default: state <= hsr_pkg::ST_IDLE;
         endcase
      end
   end

   // serialiser: one bit per system clock tick, channel 0 LSB first
   always_ff @(posedge clk_in) begin
      if (rst_in || !adc_reset_n_in) begin
         rd_addr             <= 6'h00;
         bit_idx             <= 4'h0;
         shreg               <= hsr_pkg::CNT_ZERO;
         serial_data_out     <= 1'b0;
         transmit_active_out <= 1'b0;
      end else if (clk_en_in) begin
         if (state == hsr_pkg::ST_SEND && tick && fired != '0) begin
            transmit_active_out <= 1'b1; // R11
            serial_data_out     <= rd_bin[0]; // R13
            shreg               <= rd_bin >> 1;
            rd_addr             <= rd_addr + 6'h01;
            bit_idx             <= (last_bit(res) == 4'h0) ? 4'h0 : 4'h1;
         end else if (state == hsr_pkg::ST_SEND && tick && transmit_active_out) begin
            if (bit_idx == 4'h0 && rd_addr == 6'h00) begin
               transmit_active_out <= 1'b0; // R11 R12 R14
               serial_data_out     <= 1'b0;
            end else if (bit_idx == 4'h0) begin
               serial_data_out <= rd_bin[0]; // R13
               shreg           <= rd_bin >> 1;
               rd_addr         <= rd_addr + 6'h01;
               bit_idx         <= 4'h1;
            end else begin
               serial_data_out <= shreg[0]; // R13
               shreg           <= shreg >> 1;
               bit_idx         <= bit_last ? 4'h0 : bit_idx + 4'h1; // R12 R14
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || !adc_reset_n_in) begin
         converting_out <= 1'b0;
      end else if (clk_en_in) begin
         converting_out <= (state == hsr_pkg::ST_CONV);
      end
   end

   hsr_result_mem u_result_mem (
      .clk_in      (clk_in),
      .clk_en_in   (clk_en_in),
      .wr_en_in    (wr_en),
      .wr_data_in  (wr_gray),
      .rd_addr_in  (rd_addr),
      .rd_data_out (rd_data)
   );
endmodule : hsr_adc_readout

// ==== hsr_adc_readout_sva.sv ====
// port assertions for the hold, conversion and readout block
`timescale 1ns/1ps
module hsr_adc_readout_sva (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic adc_reset_n_in,
   input wire logic start_conv_in,
   input wire logic sys_clk_in,
   input wire logic slope_sel_low_res_in,
   input wire logic slope_sel_mid_res_in,
   input wire logic serial_data_out,
   input wire logic transmit_active_out,
   input wire logic converting_out
);
   logic        sys_q;
   logic        start_q;
   logic        tick;
   logic        take;
   logic [12:0] conv_cnt;
   logic [12:0] exp_conv;
   logic [9:0]  tx_cnt;
   logic [9:0]  exp_tx;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   assign tick = sys_clk_in && !sys_q;
   assign take = start_q && !start_conv_in && adc_reset_n_in && !converting_out
                 && !transmit_active_out;
   // ticks since the start edge and while sending, selects frozen at the start edge
   always_ff @(posedge clk_in) begin
      sys_q <= sys_clk_in;
      start_q <= start_conv_in;
      conv_cnt <= take ? 13'h0000 : conv_cnt + {12'h000, tick && !transmit_active_out};
      tx_cnt <= transmit_active_out ? tx_cnt + {9'h000, tick} : 10'h000;
      if (take) begin
         exp_conv <= slope_sel_low_res_in ? 13'h0102 : slope_sel_mid_res_in ? 13'h0402 : 13'h1002;
         exp_tx <= slope_sel_low_res_in ? 10'h200 : slope_sel_mid_res_in ? 10'h280 : 10'h300;
      end
   end
   sequence s_tick_seen;
      $past(sys_clk_in) && !$past(sys_clk_in, 2);
   endsequence
   property p_start;
      take |=> ##[0:1] converting_out;
   endproperty
   a_start: assert property (p_start) else $error("start edge ignored");
   property p_auto;
      // conversion flag drops four fast clocks before the first bit, so it is still high five fast clocks back
      $rose(transmit_active_out) |-> $past(converting_out, 5);
   endproperty
   a_auto: assert property (p_auto) else $error("readout without conversion");
   property p_conv_len;
      $rose(transmit_active_out) |-> conv_cnt == exp_conv;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
   property p_tx_len;
      $fell(transmit_active_out) && $past(adc_reset_n_in) |-> tx_cnt == exp_tx;
   endproperty
   a_tx_len: assert property (p_tx_len) else $error("transmit length wrong");
   property p_idle;
      !transmit_active_out |-> !serial_data_out;
   endproperty
   a_idle: assert property (p_idle) else $error("data outside transmit");
   property p_bit_rate;
      $changed(serial_data_out) && adc_reset_n_in && $past(adc_reset_n_in) |-> s_tick_seen;
   endproperty
   a_bit_rate: assert property (p_bit_rate) else $error("data changed off tick");
   property p_abort;
      !adc_reset_n_in |=> !transmit_active_out && !converting_out && !serial_data_out;
   endproperty
   a_abort: assert property (p_abort) else $error("adc reset ignored");
   property p_reset;
      disable iff (1'b0) rst_in |=> !transmit_active_out && !converting_out && !serial_data_out;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs high after reset");
endmodule : hsr_adc_readout_sva

bind hsr_adc_readout hsr_adc_readout_sva i_hsr_adc_readout_sva (.clk_in, .rst_in,
   .adc_reset_n_in, .start_conv_in, .sys_clk_in, .slope_sel_low_res_in, .slope_sel_mid_res_in,
   .serial_data_out, .transmit_active_out, .converting_out);

// ==== hsr_ctrl_model.sv ====
// readout controller model: system clock, adc reset, start and serial capture
`timescale 1ns/1ps
module hsr_ctrl_model (
   input  wire logic   clk_in,
   input  wire logic   rst_in,
   input  wire logic   go_in,
   input  wire logic   serial_data_in,
   input  wire logic   transmit_active_in,
   output logic        sys_clk_out,
   output logic        adc_reset_n_out,
   output logic        start_conv_out,
   output logic [767:0] rx_out,
   output logic [9:0]  rx_cnt_out
);
   logic [2:0] ph = 3'h0;
   logic [2:0] low_cnt;
   logic       pend;
   // 40 MHz as five fast clocks, high for two
   assign sys_clk_out = ph < 3'h2;
   always_ff @(posedge clk_in) begin
      ph <= (rst_in || ph == 3'h4) ? 3'h0 : ph + 3'h1;
   end
   // reset dropped in the low phase so the start edge never lands on a tick
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pend <= 1'b0;
         low_cnt <= 3'h0;
         adc_reset_n_out <= 1'b1;
         start_conv_out <= 1'b1;
      end else if (go_in) begin
         pend <= 1'b1;
         start_conv_out <= 1'b1;
      end else if (pend && ph == 3'h2) begin
         pend <= 1'b0;
         adc_reset_n_out <= 1'b0;
         low_cnt <= 3'h5;
      end else if (low_cnt == 3'h1) begin
         low_cnt <= 3'h0;
         adc_reset_n_out <= 1'b1;
         start_conv_out <= 1'b0;
      end else if (low_cnt != 3'h0) begin
         low_cnt <= low_cnt - 3'h1;
      end
   end
   // sample one fast clock after the tick, before the next bit lands
   always_ff @(posedge clk_in) begin
      if (rst_in || !adc_reset_n_out) begin
         rx_cnt_out <= 10'h000;
      end else if (ph == 3'h1 && transmit_active_in) begin
         rx_out[rx_cnt_out] <= serial_data_in;
         rx_cnt_out <= rx_cnt_out + 10'h001;
      end
   end
endmodule : hsr_ctrl_model

// ==== hsr_adc_readout_tb_top.sv ====
// self-checking bench for the hold, conversion and readout block
`timescale 1ns/1ps
module hsr_adc_readout_tb_top;
   logic         clk_in = 1'b0;
   logic         rst_in = 1'b1;
   logic         peak_hold = 1'b1;
   logic         second_hold = 1'b1;
   logic         mem_sel = 1'b0;
   logic         sel_low = 1'b0;
   logic         sel_mid = 1'b0;
   logic         go = 1'b0;
   logic [767:0] amp = '0;
   logic [767:0] rx;
   logic [9:0]   rx_cnt;
   logic         sys_clk, adc_reset_n, start_conv, ser, tx, conv;
   int           fail_count = 0;
   int           total_checks = 0;
   int           cycles = 0;
   always #2.5 clk_in = ~clk_in;
   hsr_adc_readout i_hsr_adc_readout (.clk_in, .rst_in, .clk_en_in(1'b1),
      .sys_clk_in(sys_clk), .adc_reset_n_in(adc_reset_n), .start_conv_in(start_conv),
      .peak_hold_in(peak_hold), .second_hold_in(second_hold), .mem_sel_in(mem_sel),
      .slope_sel_low_res_in(sel_low), .slope_sel_mid_res_in(sel_mid), .shaper_amp_in(amp),
      .serial_data_out(ser), .transmit_active_out(tx), .converting_out(conv));
   hsr_ctrl_model i_hsr_ctrl_model (.clk_in, .rst_in, .go_in(go), .serial_data_in(ser),
      .transmit_active_in(tx), .sys_clk_out(sys_clk), .adc_reset_n_out(adc_reset_n),
      .start_conv_out(start_conv), .rx_out(rx), .rx_cnt_out(rx_cnt));
   // channel 0 of set 0 is zero, channel 63 full scale
   function automatic logic [11:0] pat(int ch, int k);
      return (ch == 63) ? 12'hFFF : 12'(ch * 65 + k * 291);
   endfunction : pat
   task automatic check(logic [11:0] got, logic [11:0] exp, string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check
   task automatic set_amp(int k);
      for (int ch = 0; ch < 64; ch++) amp[ch * 12 +: 12] <= pat(ch, k);
      repeat (3) @(posedge clk_in);
   endtask : set_amp
   task automatic pulse_go;
      go <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
   endtask : pulse_go
   task automatic load_holds;
      set_amp(0);
      peak_hold <= 1'b0;
      set_amp(1);
      second_hold <= 1'b0;
      set_amp(2);
   endtask : load_holds
   // full conversion and readout, optionally restarted by the controller in mid-readout
   task automatic run_conv(logic ms, logic lo, logic md, int n, int k, bit abort);
      logic [11:0] word;
      int          s;
      int          q;
      @(posedge clk_in);
      mem_sel <= ms;
      sel_low <= lo;
      sel_mid <= md;
      pulse_go();
      while (adc_reset_n !== 1'b0) @(posedge clk_in);
      repeat (8) @(posedge clk_in);
      check({11'h000, conv}, 12'h001, "conversion running");
      while (tx !== 1'b1) @(posedge clk_in);
      if (abort) begin
         repeat (40) @(posedge clk_in);
         pulse_go();
         while (adc_reset_n !== 1'b0) @(posedge clk_in);
         repeat (2) @(posedge clk_in);
         check({11'h000, tx}, 12'h000, "transmit during abort");
         while (tx !== 1'b1) @(posedge clk_in);
      end
      while (tx !== 1'b0) @(posedge clk_in);
      check({2'h0, rx_cnt}, 12'(64 * n), "bit count");
      s = 1 << (12 - n);
      for (int ch = 0; ch < 64; ch++) begin
         q = (pat(ch, k) + s - 1) / s;
         word = '0;
         for (int b = 0; b < n; b++) word[b] = rx[ch * n + b];
         check(word, 12'((q > (1 << n) - 1) ? (1 << n) - 1 : q), "channel word");
      end
   endtask : run_conv
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      load_holds();
      run_conv(1'b0, 1'b0, 1'b0, 12, 0, 1'b0);
      run_conv(1'b1, 1'b0, 1'b1, 10, 1, 1'b0);
      run_conv(1'b0, 1'b1, 1'b1, 8, 0, 1'b1);
      summarize();
   end
   // whole run is near 38000 cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         $display("CHECK FAILED at %0t: run did not finish", $time);
         summarize();
      end
   end
endmodule : hsr_adc_readout_tb_top
